// ### src/dprc_regs.vh
// Constants shared by the drive protection and ramp control block.
`ifndef DPRC_REGS_VH
`define DPRC_REGS_VH
`define DPRC_PL_OUT_BIT     0
`define DPRC_PL_IN_BIT      1
`define DPRC_PL_EXCH_BIT    2
`define DPRC_STALL_ACC_BIT  0
`define DPRC_STALL_RUN_BIT  1
`define DPRC_STALL_DEC_BIT  2
`define DPRC_PH_CONST       2'h0
`define DPRC_PH_ACC         2'h1
`define DPRC_PH_DEC         2'h2
`define DPRC_TRIP_NONE      4'h0
`define DPRC_TRIP_OUT_PL    4'h1
`define DPRC_TRIP_IN_PL     4'h2
`define DPRC_TRIP_HW        4'h3
`define DPRC_TRIP_DEPTH     3'h5
`define DPRC_REC_W          38
`define DPRC_REC_CODE_LSB   34
`define DPRC_REC_FREQ_LSB   18
`define DPRC_REC_CUR_LSB    2
`define DPRC_RETURN_CODE    8'h01
`define DPRC_PCT_FULL       8'h64
`define DPRC_TIME_MAX       16'h1770
`define DPRC_SCALE_10MS     2'h0
`define DPRC_SCALE_100MS    2'h1
`define DPRC_SCALE_1S       2'h2
`define DPRC_MULT_10MS      7'h01
`define DPRC_MULT_100MS     7'h0a
`define DPRC_MULT_1S        7'h64
`define DPRC_CLK_PERIOD_NS  10
`define DPRC_T_BASE_NS      10000000
`define DPRC_CYC_BASE       20'hf4240
`define DPRC_DWELL_TICKS    8'h0a
`define DPRC_SEC_TICKS      7'h64
`endif

// ### src/dprc_trip_mem.v
// Five-entry trip record store with registered read and erase.
`timescale 1ns/1ps
`include "dprc_regs.vh"
module dprc_trip_mem (
  input  wire                   clock_in,
  input  wire                   srst_in,
  input  wire                   ce_in,
  input  wire                   wr_en_in,
  input  wire [2:0]             wr_addr_in,
  input  wire [`DPRC_REC_W-1:0] wr_data_in,
  input  wire                   erase_in,
  input  wire [2:0]             rd_addr_in,
  output reg  [`DPRC_REC_W-1:0] rd_data_out,
  output reg                    rd_valid_out
);
  // Record storage; contents are never reset, only the valid flags.
  reg [`DPRC_REC_W-1:0] mem_q [0:4];
  // One valid flag per slot.
  reg [4:0]             valid_q;

  // Writes and erase; a write in the erase cycle still lands.
  always @(posedge clock_in) begin
    if (srst_in) begin
      valid_q <= 5'h00;
    end else if (ce_in) begin
      if (erase_in) begin
        valid_q <= 5'h00;
      end
      if (wr_en_in && wr_addr_in < `DPRC_TRIP_DEPTH) begin
        mem_q[wr_addr_in]   <= wr_data_in;
        valid_q[wr_addr_in] <= 1'b1;
      end
    end
  end

  // Registered read; an empty slot reads as zero.
  always @(posedge clock_in) begin
    if (srst_in) begin
      rd_data_out  <= {`DPRC_REC_W{1'b0}};
      rd_valid_out <= 1'b0;
    end else if (ce_in) begin
      if (rd_addr_in < `DPRC_TRIP_DEPTH && valid_q[rd_addr_in]) begin
        rd_data_out  <= mem_q[rd_addr_in];
        rd_valid_out <= 1'b1;
      end else begin
        rd_data_out  <= {`DPRC_REC_W{1'b0}};
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule // dprc_trip_mem

// ### src/dprc_ramp_gen.v
// Rate generator that paces one-unit frequency steps along a ramp.
`timescale 1ns/1ps
module dprc_ramp_gen (
  input  wire        clock_in,
  input  wire        srst_in,
  input  wire        ce_in,
  input  wire        enable_in,
  input  wire [15:0] span_in,
  input  wire [39:0] denom_in,
  output reg         step_out
);
  // Accumulates span each cycle; one step per denom reached.
  // This spreads span steps evenly over denom cycles without a divider.
  reg  [40:0] acc_q;
  wire [40:0] acc_sum = acc_q + {25'h0, span_in};

  // A ramp that is not moving restarts from an empty accumulator.
  always @(posedge clock_in) begin
    if (srst_in) begin
      acc_q    <= 41'h0;
      step_out <= 1'b0;
    end else if (ce_in) begin
      if (!enable_in) begin
        acc_q    <= 41'h0;
        step_out <= 1'b0;
      end else if (acc_sum >= {1'b0, denom_in}) begin
        acc_q    <= acc_sum - {1'b0, denom_in};
        step_out <= 1'b1;
      end else begin
        acc_q    <= acc_sum;
        step_out <= 1'b0;
      end
    end
  end
endmodule // dprc_ramp_gen

// ### src/dprc_top.v
// Drive protection, stall, ramp, dwell, jump and trip history control.
`timescale 1ns/1ps
`include "dprc_regs.vh"
module dprc_top #(
  parameter [19:0] CYC_BASE = `DPRC_CYC_BASE
) (
  input  wire                   clock_in,
  input  wire                   srst_in,
  input  wire                   ce_in,
  input  wire [2:0]             phase_loss_protect_bits_in,
  input  wire                   out_phase_loss_in,
  input  wire                   in_phase_loss_in,
  input  wire                   line_exchange_active_in,
  input  wire [2:0]             stall_mode_bits_in,
  input  wire [7:0]             stall_level_pct_in,
  input  wire [15:0]            rated_motor_current_in,
  input  wire [15:0]            output_current_in,
  input  wire [15:0]            base_freq_in,
  input  wire [15:0]            max_freq_in,
  input  wire [15:0]            ramp_change_freq_in,
  input  wire                   ramp_reference_sel_in,
  input  wire [1:0]             ramp_time_scale_in,
  input  wire [15:0]            accel_time_in,
  input  wire [15:0]            decel_time_in,
  input  wire [15:0]            accel_time2_in,
  input  wire [15:0]            decel_time2_in,
  input  wire                   multi_ramp_sel_low_in,
  input  wire                   multi_ramp_sel_mid_in,
  input  wire                   multi_ramp_sel_high_in,
  input  wire [15:0]            multi_accel_time_in,
  input  wire [15:0]            multi_decel_time_in,
  input  wire [15:0]            target_freq_in,
  input  wire                   forward_run_input_in,
  input  wire                   power_on_run_sel_in,
  input  wire                   watchdog_hw_fault_in,
  input  wire                   nvm_hw_fault_in,
  input  wire                   adc_offset_fault_in,
  input  wire                   fault_reset_in,
  input  wire [7:0]             group_return_code_in,
  input  wire                   code_enter_in,
  input  wire                   trip_history_erase_in,
  input  wire [2:0]             trip_history_entry_in,
  input  wire [15:0]            dwell_time_in,
  input  wire [15:0]            dwell_freq_in,
  input  wire                   sensorless_in,
  input  wire [15:0]            jump_lo1_in,
  input  wire [15:0]            jump_hi1_in,
  input  wire [15:0]            jump_lo2_in,
  input  wire [15:0]            jump_hi2_in,
  input  wire [15:0]            jump_lo3_in,
  input  wire [15:0]            jump_hi3_in,
  output reg  [15:0]            output_freq_out,
  output reg                    running_out,
  output reg                    tripped_out,
  output reg  [3:0]             trip_code_out,
  output reg                    hw_fault_lock_out,
  output reg                    stall_active_out,
  output reg  [1:0]             ramp_phase_out,
  output reg                    group_exit_out,
  output wire [`DPRC_REC_W-1:0] trip_record_out,
  output wire                   trip_record_valid_out,
  output reg  [31:0]            time_since_last_trip_out
);
  // Run states, one-hot.
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_RUN   = 4'h2;
  localparam [3:0] ST_DWELL = 4'h4;
  localparam [3:0] ST_TRIP  = 4'h8;

  // True when f lies inside band lo..hi; an empty band never hits.
  function in_band;
    input [15:0] f;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_band = (hi > lo) && (f >= lo) && (f <= hi);
    end
  endfunction

  reg  [3:0]  state_q;         // Run state.
  reg  [15:0] freq_q;          // Output frequency, 0.01 Hz units.
  reg         armed_q;         // Run command seen off since power-up or trip, or power-on run selected at reset.
  reg         first_q;         // High in the first cycle after reset.
  reg         hw_lock_q;       // Hardware fault latched until reset.
  reg         dwell_done_q;    // Dwell already served in this start.
  reg  [23:0] dwell_cnt_q;     // Dwell time in base ticks.
  reg  [15:0] goal_q;          // Goal seen at last delta ramp start.
  reg  [15:0] start_q;         // Frequency at last delta ramp start.
  reg  [19:0] base_cnt_q;      // Base tick prescaler.
  reg  [6:0]  sec_cnt_q;       // Base ticks within one second.
  reg  [2:0]  wr_ptr_q;        // Next trip record slot.
  reg         stall_q;         // Stall engaged; held until current drops.

  wire run_w    = forward_run_input_in;
  wire active_w = (state_q == ST_RUN) || (state_q == ST_DWELL);
  wire tick_w   = (base_cnt_q == CYC_BASE - 20'h1);

  wire hw_fault_w = watchdog_hw_fault_in | nvm_hw_fault_in | adc_offset_fault_in;
  wire pl_allow_w = ~line_exchange_active_in |
                    phase_loss_protect_bits_in[`DPRC_PL_EXCH_BIT];
  wire out_pl_w   = phase_loss_protect_bits_in[`DPRC_PL_OUT_BIT] & out_phase_loss_in &
                    pl_allow_w;
  wire in_pl_w    = phase_loss_protect_bits_in[`DPRC_PL_IN_BIT] & in_phase_loss_in &
                    pl_allow_w;
  wire fault_w    = hw_fault_w | out_pl_w | in_pl_w;
  wire [3:0] code_w = hw_fault_w ? `DPRC_TRIP_HW :
                      out_pl_w ? `DPRC_TRIP_OUT_PL : `DPRC_TRIP_IN_PL;

  // Jump band substitution of the reference frequency.
  // Three passes let a hit spread down a chain of overlapping bands.
  reg [15:0] jumped_w;
  integer    pass_i;           // Merge pass counter.
  always @* begin
    jumped_w = target_freq_in;
    for (pass_i = 0; pass_i < 3; pass_i = pass_i + 1) begin
      jumped_w = in_band(jumped_w, jump_lo1_in, jump_hi1_in) ? jump_lo1_in : jumped_w;
      jumped_w = in_band(jumped_w, jump_lo2_in, jump_hi2_in) ? jump_lo2_in : jumped_w;
      jumped_w = in_band(jumped_w, jump_lo3_in, jump_hi3_in) ? jump_lo3_in : jumped_w;
    end
  end

  // jump settles run only
  // Only the settling point moves; the ramp crosses a band freely.
  // stop ramps down
  wire [15:0] goal_w = (active_w && run_w) ? jumped_w : 16'h0;
  wire up_w = freq_q < goal_w;
  wire dn_w = freq_q > goal_w;
  wire [1:0] phase_w = up_w ? `DPRC_PH_ACC : (dn_w ? `DPRC_PH_DEC : `DPRC_PH_CONST);

  wire [23:0] lvl_full_w = {8'h0, rated_motor_current_in} * {16'h0, stall_level_pct_in};
  wire [23:0] lvl_w      = lvl_full_w / {16'h0, `DPRC_PCT_FULL};
  // derate above base
  // A fixed quarter cut keeps this free of a frequency divider.
  wire [23:0] lvl_eff_w  = (freq_q > base_freq_in) ? lvl_w - {2'h0, lvl_w[23:2]} : lvl_w;
  wire stall_en_w = (phase_w == `DPRC_PH_ACC)   ? stall_mode_bits_in[`DPRC_STALL_ACC_BIT] :
                    (phase_w == `DPRC_PH_DEC)   ? stall_mode_bits_in[`DPRC_STALL_DEC_BIT] :
                                                  stall_mode_bits_in[`DPRC_STALL_RUN_BIT];
  // An engaged stall holds until the current drops, whatever phase the lowering makes.
  wire stall_w = active_w && (stall_en_w || stall_q) &&
                 ({8'h0, output_current_in} > lvl_eff_w);

  wire multi_w = multi_ramp_sel_low_in | multi_ramp_sel_mid_in | multi_ramp_sel_high_in;
  // change frequency
  // A setting of zero means the second ramp is never used.
  wire chg_w = (ramp_change_freq_in != 16'h0) && (freq_q >= ramp_change_freq_in);
  wire use_dec_w = dn_w | stall_w;
  reg [15:0] time_w;
  always @* begin
    if (multi_w) begin
      time_w = use_dec_w ? multi_decel_time_in : multi_accel_time_in;
    end else if (chg_w) begin
      time_w = use_dec_w ? decel_time2_in : accel_time2_in;
    end else begin
      time_w = use_dec_w ? decel_time_in : accel_time_in;
    end
  end

  wire [15:0] time_cl_w = (time_w > `DPRC_TIME_MAX) ? `DPRC_TIME_MAX : time_w;
  wire [6:0]  mult_w = (ramp_time_scale_in == `DPRC_SCALE_1S)    ? `DPRC_MULT_1S :
                       (ramp_time_scale_in == `DPRC_SCALE_100MS) ? `DPRC_MULT_100MS :
                                                                   `DPRC_MULT_10MS;
  wire [39:0] denom_w = {24'h0, time_cl_w} * {33'h0, mult_w} * {20'h0, CYC_BASE};

  wire [15:0] delta_w = (goal_q > start_q) ? goal_q - start_q : start_q - goal_q;
  wire [15:0] span_raw_w = ramp_reference_sel_in ? delta_w : max_freq_in;
  wire [15:0] span_w = (span_raw_w == 16'h0) ? 16'h1 : span_raw_w;

  wire step_w;
  wire moving_w = active_w && (state_q != ST_DWELL || stall_w) &&
                  (up_w || dn_w || stall_w);

  // Paces frequency steps from time, scale and span.
  dprc_ramp_gen u_ramp (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .ce_in     (ce_in),
    .enable_in (moving_w),
    .span_in   (span_w),
    .denom_in  (denom_w),
    .step_out  (step_w)
  );

  wire dwell_ok_w = (dwell_time_in != 16'h0) && !sensorless_in && !dwell_done_q;
  wire [23:0] dwell_end_w = {8'h0, dwell_time_in} * {16'h0, `DPRC_DWELL_TICKS};

  // Trip record: code, frequency, current, phase.
  wire trip_evt_w = fault_w && (state_q != ST_TRIP);
  wire [`DPRC_REC_W-1:0] rec_w = {code_w, freq_q, output_current_in, phase_w};
  wire [3:0] rd_sum_w = {1'b0, wr_ptr_q} + 4'h4 - {1'b0, trip_history_entry_in};
  wire [2:0] rd_addr_w = (trip_history_entry_in >= `DPRC_TRIP_DEPTH) ? 3'h7 :
                         (rd_sum_w >= 4'h5) ? rd_sum_w[2:0] - 3'h5 : rd_sum_w[2:0];

  // Holds the trip history, newest entry read as index zero.
  dprc_trip_mem u_trips (
    .clock_in     (clock_in),
    .srst_in      (srst_in),
    .ce_in        (ce_in),
    .wr_en_in     (trip_evt_w),
    .wr_addr_in   (wr_ptr_q),
    .wr_data_in   (rec_w),
    .erase_in     (trip_history_erase_in),
    .rd_addr_in   (rd_addr_w),
    .rd_data_out  (trip_record_out),
    .rd_valid_out (trip_record_valid_out)
  );

  // Base tick prescaler and the trip timer, which erase never touches.
  always @(posedge clock_in) begin
    if (srst_in) begin
      base_cnt_q               <= 20'h0;
      sec_cnt_q                <= 7'h0;
      time_since_last_trip_out <= 32'h0;
    end else if (ce_in) begin
      base_cnt_q <= tick_w ? 20'h0 : base_cnt_q + 20'h1;
      if (trip_evt_w) begin
        sec_cnt_q                <= 7'h0;
        time_since_last_trip_out <= 32'h0;
      end else if (tick_w) begin
        if (sec_cnt_q == `DPRC_SEC_TICKS - 7'h1) begin
          sec_cnt_q <= 7'h0;
          if (time_since_last_trip_out != 32'hffffffff) begin
            time_since_last_trip_out <= time_since_last_trip_out + 32'h1;
          end
        end else begin
          sec_cnt_q <= sec_cnt_q + 7'h1;
        end
      end
    end
  end

  // Trip slot pointer; an erase restarts the ring at slot zero unless a trip lands in the same cycle.
  always @(posedge clock_in) begin
    if (srst_in) begin
      wr_ptr_q <= 3'h0;
    end else if (ce_in) begin
      if (trip_evt_w) begin
        wr_ptr_q <= (wr_ptr_q == `DPRC_TRIP_DEPTH - 3'h1) ? 3'h0 : wr_ptr_q + 3'h1;
      end else if (trip_history_erase_in) begin
        wr_ptr_q <= 3'h0;
      end
    end
  end

  // Main run control: start, dwell, ramp, stall and trip.
  always @(posedge clock_in) begin
    if (srst_in) begin
      state_q      <= ST_IDLE;
      freq_q       <= 16'h0;
      armed_q      <= 1'b0;
      first_q      <= 1'b1;
      hw_lock_q    <= 1'b0;
      dwell_done_q <= 1'b0;
      dwell_cnt_q  <= 24'h0;
      goal_q       <= 16'h0;
      start_q      <= 16'h0;
      stall_q      <= 1'b0;
    end else if (ce_in) begin
      first_q <= 1'b0;
      stall_q <= stall_w;
      if (!run_w || (first_q && power_on_run_sel_in)) begin
        armed_q <= 1'b1;
      end
      // A new goal restarts the delta ramp from where we stand.
      if (goal_w != goal_q) begin
        goal_q  <= goal_w;
        start_q <= freq_q;
      end
      if (hw_fault_w) begin
        hw_lock_q <= 1'b1;
      end
      if (trip_evt_w) begin
        // Output is cut at once; the motor coasts.
        state_q <= ST_TRIP;
        freq_q  <= 16'h0;
        armed_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            dwell_done_q <= 1'b0;
            if (armed_q && run_w) begin
              state_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (stall_w && step_w && freq_q != 16'h0) begin
              freq_q <= freq_q - 16'h1;
            end else if (up_w && dwell_ok_w && freq_q >= dwell_freq_in) begin
              state_q     <= ST_DWELL;
              dwell_cnt_q <= 24'h0;
            end else if (step_w && up_w) begin
              freq_q <= freq_q + 16'h1;
            end else if (step_w && dn_w) begin
              freq_q <= freq_q - 16'h1;
            end else if (!run_w && freq_q == 16'h0) begin
              state_q <= ST_IDLE;
            end
          end
          ST_DWELL: begin
            if (stall_w && step_w && freq_q != 16'h0) begin
              freq_q <= freq_q - 16'h1;
            end
            if (!run_w || dwell_cnt_q >= dwell_end_w) begin
              state_q      <= ST_RUN;
              dwell_done_q <= 1'b1;
            end else if (tick_w) begin
              dwell_cnt_q <= dwell_cnt_q + 24'h1;
            end
          end
          ST_TRIP: begin
            if (fault_reset_in && !hw_lock_q && !fault_w) begin
              state_q <= ST_IDLE;
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Registered status outputs.
  always @(posedge clock_in) begin
    if (srst_in) begin
      output_freq_out   <= 16'h0;
      running_out       <= 1'b0;
      tripped_out       <= 1'b0;
      trip_code_out     <= `DPRC_TRIP_NONE;
      hw_fault_lock_out <= 1'b0;
      stall_active_out  <= 1'b0;
      ramp_phase_out    <= `DPRC_PH_CONST;
      group_exit_out    <= 1'b0;
    end else if (ce_in) begin
      output_freq_out   <= freq_q;
      running_out       <= active_w;
      tripped_out       <= (state_q == ST_TRIP);
      hw_fault_lock_out <= hw_lock_q;
      stall_active_out  <= stall_w;
      ramp_phase_out    <= active_w ? phase_w : `DPRC_PH_CONST;
      if (trip_evt_w) begin
        trip_code_out <= code_w;
      end
      group_exit_out <= code_enter_in && (group_return_code_in == `DPRC_RETURN_CODE);
    end
  end
endmodule // dprc_top

// ### dv/dprc_motor.sv
// Behavioural motor load that answers the drive frequency with a current.
`timescale 1ns/1ps
module dprc_motor (
  input  wire         clock_in,
  input  wire  [15:0] freq_in,
  input  wire         overload_in,
  output logic [15:0] current_out = 16'h0000
);
  // Current lags speed by a cycle, as a real load never answers at once.
  // A jam forces twice the rated level so the stall logic must act.
  always @(posedge clock_in) begin
    current_out <= overload_in ? 16'h00c8 : (freq_in >> 1);
  end
endmodule // dprc_motor

// ### dv/dprc_top_properties.sv
// Port-level assertions and covers for the protection and ramp block.
`timescale 1ns/1ps
module dprc_top_properties (
  input wire        clock_in,
  input wire        srst_in,
  input wire [2:0]  phase_loss_protect_bits_in,
  input wire        out_phase_loss_in,
  input wire        in_phase_loss_in,
  input wire        line_exchange_active_in,
  input wire        watchdog_hw_fault_in,
  input wire        nvm_hw_fault_in,
  input wire        adc_offset_fault_in,
  input wire [7:0]  group_return_code_in,
  input wire        code_enter_in,
  input wire        trip_history_erase_in,
  input wire        forward_run_input_in,
  input wire [15:0] output_freq_out,
  input wire        running_out,
  input wire        tripped_out,
  input wire        hw_fault_lock_out,
  input wire        stall_active_out,
  input wire        group_exit_out,
  input wire        trip_record_valid_out,
  input wire [31:0] time_since_last_trip_out
);
  default clocking dc @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Any enabled loss not masked by line exchange, or any hardware fault, must lead to a trip.
  wire [2:0] pb     = phase_loss_protect_bits_in;
  wire       hw     = watchdog_hw_fault_in | nvm_hw_fault_in | adc_offset_fault_in;
  wire       loss   = (pb[0] & out_phase_loss_in) | (pb[1] & in_phase_loss_in);
  wire       cause  = hw | (loss & (!line_exchange_active_in | pb[2]));
  wire       code_ok = code_enter_in & (group_return_code_in == 8'h01);
  a_loss_trips: assert property (cause && !tripped_out |-> ##[1:2] tripped_out)
    else $error("enabled fault did not trip");
  a_trip_cause: assert property ($rose(tripped_out) |-> $past(cause, 2))
    else $error("trip without enabled cause");
  a_trip_stops: assert property (tripped_out |-> output_freq_out == 16'h0000)
    else $error("output running while tripped");
  a_hw_lock_holds: assert property (hw_fault_lock_out && tripped_out |=>
    hw_fault_lock_out && tripped_out) else $error("hardware trip was released");
  a_exit_on_code: assert property (code_ok |=> group_exit_out)
    else $error("group exit missing");
  a_exit_has_code: assert property (group_exit_out |-> $past(code_ok))
    else $error("group exit without code");
  a_erase_clears: assert property (trip_history_erase_in && !cause ##1 !cause ##1 !cause
    |-> ##[0:1] !trip_record_valid_out) else $error("erase left a record");
  a_timer_kept: assert property (trip_history_erase_in && !cause |=>
    time_since_last_trip_out >= $past(time_since_last_trip_out)) else $error("timer cleared");
  a_run_needs_cmd: assert property ($rose(running_out) |-> $past(forward_run_input_in, 2))
    else $error("run without command");
  c_trip: cover property ($rose(tripped_out));
  c_stall: cover property ($rose(stall_active_out));
  c_exit: cover property (group_exit_out);
endmodule // dprc_top_properties

bind dprc_top dprc_top_properties dprc_top_properties_i (.*);

// ### dv/dprc_top_tb.sv
// Self-checking bench for the drive protection and ramp control block.
`timescale 1ns/1ps
`include "dprc_regs.vh"
module dprc_top_tb;
  // One second is a hundred cycles here, so the run stays short.
  logic clock_in = 1'b0, srst_in = 1'b1, ce_in = 1'b1, overload;
  logic out_phase_loss_in, in_phase_loss_in, line_exchange_active_in, ramp_reference_sel_in;
  logic multi_ramp_sel_low_in, multi_ramp_sel_mid_in, multi_ramp_sel_high_in, sensorless_in;
  logic forward_run_input_in, power_on_run_sel_in, watchdog_hw_fault_in, nvm_hw_fault_in;
  logic adc_offset_fault_in, fault_reset_in, code_enter_in, trip_history_erase_in;
  logic running_out, tripped_out, hw_fault_lock_out, stall_active_out, group_exit_out;
  logic trip_record_valid_out;
  logic [1:0] ramp_time_scale_in, ramp_phase_out;
  logic [2:0] phase_loss_protect_bits_in, stall_mode_bits_in, trip_history_entry_in;
  logic [3:0] trip_code_out;
  logic [7:0] stall_level_pct_in, group_return_code_in;
  logic [15:0] rated_motor_current_in, output_current_in, base_freq_in, max_freq_in;
  logic [15:0] ramp_change_freq_in, accel_time_in, decel_time_in, accel_time2_in;
  logic [15:0] decel_time2_in, multi_accel_time_in, multi_decel_time_in, target_freq_in;
  logic [15:0] dwell_time_in, dwell_freq_in, jump_lo1_in, jump_hi1_in, jump_lo2_in;
  logic [15:0] jump_hi2_in, jump_lo3_in, jump_hi3_in, output_freq_out;
  logic [`DPRC_REC_W-1:0] trip_record_out;
  logic [31:0] time_since_last_trip_out, t0;
  int miscompares = 0, n_checks = 0, cycles = 0;
  dprc_top #(.CYC_BASE(20'h00001)) dprc_top_i (.*);
  dprc_motor dprc_motor_i (.clock_in(clock_in), .freq_in(output_freq_out),
    .overload_in(overload), .current_out(output_current_in));
  always #5 clock_in = ~clock_in;
  // A hang counts as a mismatch and still ends in the report.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic results;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run held through reset must wait for a fresh command edge.
  task automatic t_power_on;
    tick(20);
    chk(running_out, 1'b0);
    forward_run_input_in = 1'b0;
    tick(2);
    forward_run_input_in = 1'b1;
    tick(300);
    chk(running_out, 1'b1);
    chk(output_freq_out, 16'h001e);
    chk(ramp_phase_out, `DPRC_PH_CONST);
    $display("power-on and jump test done");
  endtask
  // A jam in constant run only stalls when the run-phase bit is set.
  task automatic t_stall;
    stall_mode_bits_in = 3'h1;
    overload = 1'b1;
    tick(10);
    chk(stall_active_out, 1'b0);
    stall_mode_bits_in = 3'h2;
    tick(10);
    chk(stall_active_out, 1'b1);
    chk(output_freq_out < 16'h001e, 1'b1);
    overload = 1'b0;
    stall_mode_bits_in = 3'h0;
    tick(100);
    $display("stall test done");
  endtask
  // A stop at the 0.1 s scale paces one unit every ten cycles.
  task automatic t_scale;
    ramp_time_scale_in = `DPRC_SCALE_100MS;
    forward_run_input_in = 1'b0;
    tick(100);
    chk(output_freq_out >= 16'h0014 && output_freq_out <= 16'h0015, 1'b1);
    chk(ramp_phase_out, `DPRC_PH_DEC);
    ramp_time_scale_in = `DPRC_SCALE_10MS;
    forward_run_input_in = 1'b1;
    tick(50);
    $display("time scale test done");
  endtask
  // Each row: enables, exchange, out loss, in loss, then expected code.
  task automatic t_trips;
    logic [9:0] tv [5] = '{10'h020, 10'h0a1, 10'h112, 10'h1e0, 10'h3d2};
    foreach (tv[i]) begin
      {phase_loss_protect_bits_in, line_exchange_active_in, out_phase_loss_in,
        in_phase_loss_in} = tv[i][9:4];
      tick(5);
      chk(tripped_out ? trip_code_out : 4'h0, tv[i][3:0]);
      {out_phase_loss_in, in_phase_loss_in, fault_reset_in} = 3'h1;
      tick(1);
      fault_reset_in = 1'b0;
      tick(2);
    end
    trip_history_entry_in = 3'h2;
    tick(2);
    chk({trip_record_out[37:18], trip_record_out[1:0]}, {4'h1, 16'h001e, `DPRC_PH_CONST});
    t0 = time_since_last_trip_out;
    trip_history_erase_in = 1'b1;
    tick(1);
    trip_history_erase_in = 1'b0;
    tick(3);
    chk(trip_record_valid_out, 1'b0);
    chk(time_since_last_trip_out >= t0, 1'b1);
    $display("trip history test done");
  endtask
  task automatic t_exit;
    for (int c = 0; c < 3; c++) begin
      group_return_code_in = c[7:0];
      code_enter_in = 1'b1;
      tick(1);
      code_enter_in = 1'b0;
      chk(group_exit_out, c == 1);
      tick(1);
    end
    $display("group exit test done");
  endtask
  // Every hardware fault locks the trip; only a reset frees it.
  task automatic t_hw;
    power_on_run_sel_in = 1'b1;
    for (int i = 0; i < 3; i++) begin
      {watchdog_hw_fault_in, nvm_hw_fault_in, adc_offset_fault_in} = 3'h1 << i;
      tick(1);
      {watchdog_hw_fault_in, nvm_hw_fault_in, adc_offset_fault_in} = 3'h0;
      tick(3);
      fault_reset_in = 1'b1;
      tick(2);
      fault_reset_in = 1'b0;
      chk({tripped_out, hw_fault_lock_out, trip_code_out}, 6'h33);
      srst_in = 1'b1;
      tick(2);
      srst_in = 1'b0;
    end
    tick(20);
    chk(running_out, 1'b1);
    $display("hardware fault test done");
  endtask
  initial begin
    {out_phase_loss_in, in_phase_loss_in, line_exchange_active_in, ramp_reference_sel_in,
      multi_ramp_sel_low_in, multi_ramp_sel_mid_in, multi_ramp_sel_high_in, sensorless_in,
      power_on_run_sel_in, watchdog_hw_fault_in, nvm_hw_fault_in, adc_offset_fault_in,
      fault_reset_in, code_enter_in, trip_history_erase_in, overload, ramp_time_scale_in,
      phase_loss_protect_bits_in, stall_mode_bits_in, trip_history_entry_in,
      group_return_code_in, ramp_change_freq_in, dwell_time_in, jump_lo3_in, jump_hi3_in} = '0;
    {rated_motor_current_in, base_freq_in, max_freq_in, accel_time_in, decel_time_in,
      accel_time2_in, decel_time2_in, multi_accel_time_in, multi_decel_time_in} = {9{16'h0064}};
    {jump_lo1_in, jump_hi1_in, jump_lo2_in, jump_hi2_in} = 64'h0028_003c_001e_0030;
    {stall_level_pct_in, target_freq_in, dwell_freq_in} = 40'h64_0032_01f4;
    forward_run_input_in = 1'b1;
    tick(2);
    srst_in = 1'b0;
    t_power_on();
    t_stall();
    t_scale();
    t_trips();
    t_exit();
    t_hw();
    results();
  end
endmodule // dprc_top_tb
